// ---- logic/flash_host_pkg.sv ----
`default_nettype none
package flash_host_pkg;
  // Pin widths
  localparam int ADDR_W      = 21;     // Word address bits
  localparam int DATA_W      = 16;     // Data pins
  // Bus cycle timing in ns and derived cycles at 250 MHz
  localparam int CLK_PERIOD_NS = 4;
  localparam int ACCESS_NS     = 70;   // Least read access time
  localparam int WRPULSE_NS    = 35;   // Least write strobe width
  localparam int RECOVER_NS    = 20;   // Least strobe high time
  localparam int RESET_NS      = 500;  // Least reset pulse width
  localparam int ACCESS_CYC  = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WRPULSE_CYC = (WRPULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RECOVER_CYC = (RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESET_CYC   = (RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W       = 8;
  // Automatic-select code locations (address bits A1, A0)
  localparam logic [1:0] SEL_MFR     = 2'h0;
  localparam logic [1:0] SEL_DEV     = 2'h1;
  localparam logic [1:0] SEL_PROTECT = 2'h2;
  localparam logic [1:0] SEL_SECURE  = 2'h3;
  // Indicator codes
  localparam logic [7:0] CODE_UNPROT    = 8'h00;
  localparam logic [7:0] CODE_PROT      = 8'h01;
  localparam logic [7:0] CODE_SEC_LOCK  = 8'h99;
  localparam logic [7:0] CODE_SEC_OPEN  = 8'h19;
  // Operation requests
  typedef enum logic [1:0] {
    OP_READ  = 2'h0,
    OP_WRITE = 2'h1,
    OP_RESET = 2'h2
  } op_t;
  // Bus sequencer states, one-hot
  typedef enum logic [4:0] {
    ST_IDLE  = 5'h01,
    ST_READ  = 5'h02,
    ST_WRITE = 5'h04,
    ST_RECOV = 5'h08,
    ST_RESET = 5'h10
  } state_t;
  // Whole sequencer state
  typedef struct packed {
    state_t              st;
    logic [CNT_W-1:0]    cnt;
    logic                wrOp;
    logic [ADDR_W:0]     addr;
    logic [DATA_W-1:0]   wdata;
    logic [DATA_W-1:0]   rdata;
    logic                done;
    logic                accel;
    logic                nCe;
    logic                nOe;
    logic                nWe;
    logic                nRst;
    logic                drive;
  } host_t;
endpackage
`default_nettype wire

// ---- logic/flash_bus_host.sv ----
// Notes on behaviour
// - Read: select, gate low, strobe high
// - Write: select, strobe low, gate high
// - 21 word address bits, A-1 in byte
// - Accelerate voltage only while programming
// - Sector address is upper address bits
`timescale 1ns/10ps
`default_nettype none
module flash_bus_host
  import flash_host_pkg::*;
#(
  parameter int AW = ADDR_W
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              clkEn,
  // User request side
  input  wire logic              reqValid,
  output logic                   reqReady,
  input  wire op_t               reqOp,
  input  wire logic [AW:0]       reqAddr,    // Bit 0 is A-1 in byte mode
  input  wire logic [DATA_W-1:0] reqWdata,
  input  wire logic              reqAccel,   // Ask for accelerate on a write
  input  wire logic              byteMode,
  output logic                   rspValid,
  output logic [DATA_W-1:0]      rspData,
  // Flash pins
  output logic [AW-1:0]          flashAddr,
  output logic                   flashCe_n,
  output logic                   flashOe_n,
  output logic                   flashWe_n,
  output logic                   flashReset_n,
  output logic                   flashByte_n,
  output logic                   accelEnable, // Raise protect_accel_pin to accel_high_voltage
  input  wire logic [DATA_W-1:0] flashDqIn,
  output logic [DATA_W-1:0]      flashDqOut,
  output logic [DATA_W-1:0]      flashDqOe
);
  host_t s;       // Registered state
  host_t next_s;  // Next state

  // Decode the upper-data driving pattern for a given width
  function automatic logic [DATA_W-1:0] dq_mask(input logic byteW, input logic drv);
    logic [DATA_W-1:0] m;
    m = '0;
    if (drv) begin
      m = byteW ? {1'b0, 7'h00, 8'hFF} : 16'hFFFF;
    end
    if (byteW) begin
      m[DATA_W-1] = 1'b1;                          // Q15 carries A-1 always
    end
    return m;
  endfunction

  // Sequencer next state
  always_comb begin
    next_s      = s;
    next_s.done = 1'b0;
    case (s.st)
      ST_IDLE: begin
        // Leave the power-up reset at the first enabled edge, else reads see a dead bus
        next_s.nRst = 1'b1;
        if (reqValid) begin
          next_s.addr  = reqAddr;
          next_s.wdata = reqWdata;
          next_s.cnt   = '0;
          if (reqOp == OP_RESET) begin
            next_s.st   = ST_RESET;
            next_s.nRst = 1'b0;
          end else if (reqOp == OP_WRITE) begin
            next_s.st    = ST_WRITE;
            next_s.wrOp  = 1'b1;
            next_s.nCe   = 1'b0;
            next_s.nWe   = 1'b0;
            next_s.nOe   = 1'b1;
            next_s.drive = 1'b1;
            next_s.accel = reqAccel;
          end else begin
            next_s.st   = ST_READ;
            next_s.wrOp = 1'b0;
            next_s.nCe  = 1'b0;
            next_s.nOe  = 1'b0;
            next_s.nWe  = 1'b1;
          end
        end
      end
      ST_READ: begin
        next_s.cnt = s.cnt + CNT_W'(1);
        if (s.cnt == CNT_W'(ACCESS_CYC - 1)) begin
          next_s.rdata = flashDqIn;
          next_s.st    = ST_RECOV;
          next_s.cnt   = '0;
          next_s.nCe   = 1'b1;
          next_s.nOe   = 1'b1;
        end
      end
      ST_WRITE: begin
        next_s.cnt = s.cnt + CNT_W'(1);
        if (s.cnt == CNT_W'(WRPULSE_CYC - 1)) begin
          next_s.st  = ST_RECOV;
          next_s.cnt = '0;
          next_s.nWe = 1'b1;                     // Data latched on rising strobe
          next_s.nCe = 1'b1;
        end
      end
      ST_RECOV: begin
        // Strobes high, data held one recovery time
        next_s.cnt = s.cnt + CNT_W'(1);
        if (s.cnt == CNT_W'(RECOVER_CYC - 1)) begin
          next_s.st    = ST_IDLE;
          next_s.drive = 1'b0;
          next_s.accel = 1'b0;
          next_s.done  = 1'b1;
        end
      end
      ST_RESET: begin
        next_s.cnt = s.cnt + CNT_W'(1);
        if (s.cnt == CNT_W'(RESET_CYC - 1)) begin
          next_s.nRst = 1'b1;
          next_s.st   = ST_RECOV;
          next_s.cnt  = '0;
        end
      end
      default: begin
        next_s.st = ST_IDLE;
      end
    endcase
  end

  // State register with clock enable
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s       <= '0;
      s.st    <= ST_IDLE;
      s.nCe   <= 1'b1;
      s.nOe   <= 1'b1;
      s.nWe   <= 1'b1;
      s.nRst  <= 1'b0;  // Hold device in reset while we are
    end else if (clkEn) begin
      s <= next_s;
    end
  end

  // Outputs
  assign reqReady     = (s.st == ST_IDLE);
  assign rspValid     = s.done;
  assign rspData      = s.rdata;
  // Byte mode moves the word address up one; bit 0 leaves on the top data pin
  assign flashAddr    = byteMode ? s.addr[AW:1] : s.addr[AW-1:0];
  assign flashCe_n    = s.nCe;
  assign flashOe_n    = s.nOe;
  assign flashWe_n    = s.nWe;
  assign flashReset_n = s.nRst;
  assign flashByte_n  = ~byteMode;
  assign accelEnable  = s.accel & s.wrOp;
  // Per-bit enables; data is kept driven through recovery for hold time
  assign flashDqOe    = dq_mask(byteMode, s.drive);
  assign flashDqOut   = byteMode ? {s.addr[0], 7'h00, s.wdata[7:0]} : s.wdata;

  // Checks
  property p_noContention;
    @(posedge clk) disable iff (rst) !(s.nOe == 1'b0 && s.drive);
  endproperty
  a_noContention: assert property (p_noContention) else $error("read with data driven");

  property p_writeStrobes;
    @(posedge clk) disable iff (rst) (s.nWe == 1'b0) |-> (s.nCe == 1'b0 && s.nOe == 1'b1);
  endproperty
  a_writeStrobes: assert property (p_writeStrobes) else $error("bad write strobes");

  property p_accelOnlyWrite;
    @(posedge clk) disable iff (rst) accelEnable |-> (s.st == ST_WRITE || s.st == ST_RECOV);
  endproperty
  a_accelOnlyWrite: assert property (p_accelOnlyWrite) else $error("accel outside write");

  property p_readStrobes;
    @(posedge clk) disable iff (rst) (s.nOe == 1'b0) |-> (s.nCe == 1'b0 && s.nWe == 1'b1);
  endproperty
  a_readStrobes: assert property (p_readStrobes) else $error("bad read strobes");

  property p_resetIdle;
    @(posedge clk) disable iff (rst) (s.nRst == 1'b0) |-> (s.nWe && s.nOe);
  endproperty
  a_resetIdle: assert property (p_resetIdle) else $error("cycle during reset");

  property p_byteA1;
    @(posedge clk) disable iff (rst) byteMode |-> flashDqOe[DATA_W-1];
  endproperty
  a_byteA1: assert property (p_byteA1) else $error("A-1 not driven");

  property p_accelDrop;
    @(posedge clk) disable iff (rst || !clkEn) (s.st == ST_IDLE) |-> !accelEnable;
  endproperty
  a_accelDrop: assert property (p_accelDrop) else $error("accel held idle");

  property p_readAccess;
    @(posedge clk) disable iff (rst) (s.st == ST_IDLE && clkEn && reqValid && reqOp == OP_READ)
      |=> (s.nOe == 1'b0);
  endproperty
  a_readAccess: assert property (p_readAccess) else $error("read not started");

  c_read:  cover property (@(posedge clk) rspValid && !s.wrOp);
  c_write: cover property (@(posedge clk) s.nWe == 1'b0);
  c_accel: cover property (@(posedge clk) accelEnable);
  c_reset: cover property (@(posedge clk) disable iff (rst) s.st == ST_RESET);
endmodule
`default_nettype wire

// ---- dv/flash_dev_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module flash_dev_model
  import flash_host_pkg::*;
#(
  parameter logic [7:0] MFR_CODE = 8'h5A,  // Arbitrary value
  parameter logic [7:0] DEV_CODE = 8'h3C   // Arbitrary value
) (
  // Flash pins
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic              ceN,
  input  wire logic              oeN,
  input  wire logic              weN,
  input  wire logic              resetN,
  input  wire logic              byteN,
  input  wire logic              accelEn,
  input  wire logic [DATA_W-1:0] dqBus,
  output logic [DATA_W-1:0]      dq,
  // Counters seen by the bench
  output int                     accelMisuse,
  output int                     accelWrites
);
  logic [DATA_W-1:0] mem [16];  // Small array, low address bits only
  logic [2:0]        seq;       // Command step
  logic              autoSel;   // Code register selected
  logic [DATA_W-1:0] rd;
  logic [DATA_W-1:0] lastRd;    // Released bus shows its inverse
  logic [7:0]        code;
  wire drv = !ceN && !oeN && weN && resetN;
  initial begin
    for (int i = 0; i < 16; i++) mem[i] = 16'hA500 | 16'(i);
    seq = 0; autoSel = 0; accelMisuse = 0; accelWrites = 0;
  end
  // Hardware reset returns to array read
  always @(negedge resetN) begin
    seq = 0; autoSel = 0;
  end
  // Commands latched where the write ends, whichever strobe rises first
  wire wrSel = !ceN && !weN && oeN && resetN;
  always @(negedge wrSel) if (resetN) begin
    if (accelEn) accelWrites++;
    case (seq)
      3'h0: begin
        if (dqBus[7:0] == 8'hF0) autoSel = 0;
        seq = (addr[10:0] == 11'h555 && dqBus[7:0] == 8'hAA) ? 3'h1 : 3'h0;
      end
      3'h1: seq = (addr[10:0] == 11'h2AA && dqBus[7:0] == 8'h55) ? 3'h2 : 3'h0;
      3'h2: begin
        if (addr[10:0] == 11'h555 && dqBus[7:0] == 8'h90) autoSel = 1;
        if (addr[10:0] == 11'h555 && dqBus[7:0] == 8'hA0) seq = 3'h3;
        else if (addr[10:0] == 11'h555 && dqBus[7:0] == 8'h80) seq = 3'h4;
        else seq = 3'h0;
      end
      3'h3: begin mem[addr[3:0]] = dqBus; seq = 0; end
      3'h4: seq = (addr[10:0] == 11'h555 && dqBus[7:0] == 8'hAA) ? 3'h5 : 3'h0;
      3'h5: seq = (addr[10:0] == 11'h2AA && dqBus[7:0] == 8'h55) ? 3'h6 : 3'h0;
      default: begin
        // Chip erase, or erase of the one sector that holds the small array
        if ((addr[10:0] == 11'h555 && dqBus[7:0] == 8'h10) ||
            (addr[20:12] == 9'h000 && dqBus[7:0] == 8'h30))
          for (int i = 0; i < 16; i++) mem[i] = 16'hFFFF;
        seq = 0;
      end
    endcase
  end
  // Accelerate voltage outside programming
  always @(negedge oeN) if (accelEn) accelMisuse++;
  // Read path: codes on low byte, the sector at upper address bits zero protected unless accelerated
  always_comb begin
    case (addr[1:0])
      SEL_MFR: code = MFR_CODE;
      SEL_DEV: code = DEV_CODE;
      SEL_PROTECT: code = (addr[20:12] == 0 && !accelEn) ? CODE_PROT : CODE_UNPROT;
      default: code = CODE_SEC_LOCK;
    endcase
    rd = autoSel ? {8'h00, code} : mem[addr[3:0]];
    if (!byteN) rd = {~lastRd[15:8], dqBus[15] ? rd[15:8] : rd[7:0]};
  end
  always @(negedge drv) lastRd = rd;
  assign dq = drv ? rd : ~lastRd;
endmodule
`default_nettype wire

// ---- dv/tb_flash_bus_host.sv ----
`timescale 1ns/10ps
`default_nettype none
module tb_flash_bus_host
  import flash_host_pkg::*;
;
  localparam logic [7:0] MFR = 8'h5A;  // Arbitrary value
  localparam logic [7:0] DEV = 8'h3C;  // Arbitrary value
  logic clk = 0, rst = 1, reqValid = 0, reqAccel = 0, byteMode = 0;
  op_t reqOp = OP_READ;
  logic [ADDR_W:0] reqAddr = 0;
  logic [DATA_W-1:0] reqWdata = 0, rspData, dqOut, dqOe, dq, rdat;
  logic reqReady, rspValid, ceN, oeN, weN, resetN, byteN, accelEn;
  logic [ADDR_W-1:0] fAddr;
  int n_mismatch = 0, n_compared = 0, misuse, accW;
  wire [DATA_W-1:0] bus = (dqOe & dqOut) | (~dqOe & dq);  // Resolved data pins
  initial forever #2 clk = ~clk;
  flash_bus_host flash_bus_host_inst (.clk(clk), .rst(rst), .clkEn(1'b1),
    .reqValid(reqValid), .reqReady(reqReady), .reqOp(reqOp), .reqAddr(reqAddr),
    .reqWdata(reqWdata), .reqAccel(reqAccel), .byteMode(byteMode),
    .rspValid(rspValid), .rspData(rspData), .flashAddr(fAddr), .flashCe_n(ceN),
    .flashOe_n(oeN), .flashWe_n(weN), .flashReset_n(resetN), .flashByte_n(byteN),
    .accelEnable(accelEn), .flashDqIn(bus), .flashDqOut(dqOut), .flashDqOe(dqOe));
  flash_dev_model #(.MFR_CODE(MFR), .DEV_CODE(DEV)) flash_dev_model_inst (
    .addr(fAddr), .ceN(ceN), .oeN(oeN), .weN(weN), .resetN(resetN), .byteN(byteN),
    .accelEn(accelEn), .dqBus(bus), .dq(dq), .accelMisuse(misuse), .accelWrites(accW));
  task automatic report_and_stop();
    $display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic cmp(input string nm, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // One request, held until taken, then wait for the answer
  task automatic op(input op_t o, input logic [21:0] a, input logic [15:0] d, input logic ac);
    int k;
    @(negedge clk);
    reqValid = 1; reqOp = o; reqAddr = a; reqWdata = d; reqAccel = ac;
    k = 0;
    while (reqReady !== 1'b1 && k < 50) begin @(negedge clk); k++; end
    if (k >= 50) begin n_mismatch++; report_and_stop(); end
    @(negedge clk);
    reqValid = 0; reqAccel = 0;
    k = 0;
    while (rspValid !== 1'b1 && k < 400) begin @(negedge clk); k++; end
    if (k >= 400) begin n_mismatch++; report_and_stop(); end
    rdat = rspData;
  endtask
  task automatic unlock(input logic [7:0] c);
    op(OP_WRITE, 22'h555, 16'h00AA, 0);
    op(OP_WRITE, 22'h2AA, 16'h0055, 0);
    op(OP_WRITE, 22'h555, {8'h00, c}, 0);
  endtask
  // Plain read after reset returns array data
  task automatic t_boot();
    op(OP_READ, 22'h5, 0, 0); cmp("boot read", 16'hA505, rdat);
  endtask
  // Program then read back
  task automatic t_prog();
    unlock(8'hA0); op(OP_WRITE, 22'h6, 16'h1234, 0);
    op(OP_READ, 22'h6, 0, 0); cmp("program", 16'h1234, rdat);
  endtask
  // Broken unlock leaves the array untouched
  task automatic t_bad();
    op(OP_WRITE, 22'h555, 16'h00AA, 0); op(OP_WRITE, 22'h2AA, 16'h0077, 0);
    op(OP_WRITE, 22'h555, 16'h00A0, 0); op(OP_WRITE, 22'h7, 16'hBEEF, 0);
    op(OP_READ, 22'h7, 0, 0); cmp("bad sequence", 16'hA507, rdat);
  endtask
  // Code register reads, then reset back to array
  task automatic t_auto();
    unlock(8'h90);
    op(OP_READ, 22'h0, 0, 0); cmp("maker code", {8'h00, MFR}, rdat);
    op(OP_READ, 22'h1, 0, 0); cmp("part code", {8'h00, DEV}, rdat);
    op(OP_READ, 22'h2, 0, 0); cmp("boot protect", {8'h00, CODE_PROT}, rdat);
    op(OP_READ, 22'h1002, 0, 0); cmp("unprotected", {8'h00, CODE_UNPROT}, rdat);
    op(OP_READ, 22'h3, 0, 0); cmp("security", {8'h00, CODE_SEC_LOCK}, rdat);
    op(OP_RESET, 22'h0, 0, 0); op(OP_READ, 22'h0, 0, 0);
    cmp("after reset", 16'hA500, rdat);
  endtask
  // Accelerated program, voltage only on the data write
  task automatic t_accel();
    unlock(8'hA0); op(OP_WRITE, 22'h8, 16'h0F0F, 1);
    op(OP_READ, 22'h8, 0, 0); cmp("accel data", 16'h0F0F, rdat);
    cmp("accel writes", 16'h1, 16'(accW));
    cmp("accel misuse", 16'h0, 16'(misuse));
  endtask
  // Byte mode: A-1 on the top data pin selects the byte
  task automatic t_byte();
    byteMode = 1;
    op(OP_READ, 22'hD, 0, 0); cmp("high byte", 16'h12, {8'h00, rdat[7:0]});
    op(OP_READ, 22'hC, 0, 0); cmp("low byte", 16'h34, {8'h00, rdat[7:0]});
    cmp("byte pin", 16'h0, {15'h0, byteN});
    @(negedge clk) byteMode = 0;
  endtask
  // Host reset in mid-run pulls the device back to array read
  task automatic t_hostRst();
    unlock(8'h90);
    @(negedge clk) rst = 1;
    @(negedge clk) cmp("reset pin", 16'h0, {15'h0, resetN});
    repeat (5) @(negedge clk);
    rst = 0;
    op(OP_READ, 22'h0, 0, 0); cmp("host reset read", 16'hA500, rdat);
  endtask
  // Erase: another sector keeps the array, a chip erase clears it
  task automatic t_erase();
    unlock(8'h80); op(OP_WRITE, 22'h555, 16'h00AA, 0); op(OP_WRITE, 22'h2AA, 16'h0055, 0);
    op(OP_WRITE, 22'h1000, 16'h0030, 0);
    op(OP_READ, 22'h5, 0, 0); cmp("other sector erase", 16'hA505, rdat);
    unlock(8'h80); op(OP_WRITE, 22'h555, 16'h00AA, 0); op(OP_WRITE, 22'h2AA, 16'h0055, 0);
    op(OP_WRITE, 22'h555, 16'h0010, 0);
    op(OP_READ, 22'h5, 0, 0); cmp("chip erase", 16'hFFFF, rdat);
  endtask
  initial begin
    repeat (6) @(posedge clk);
    @(negedge clk) rst = 0;
    t_boot(); t_prog(); t_bad(); t_auto(); t_accel(); t_byte();
    t_hostRst(); t_erase();
    report_and_stop();
  end
endmodule
`default_nettype wire
